//--- include/tlm_pkg.sv
// Package for the toner level monitor: timing constants and state types.
// Assumes a 20 MHz system clock.
package tlm_pkg;
  localparam int unsigned TLM_CLK_HZ = 20000000;
  // Nominal stirring-bar revolution, in milliseconds
  localparam int unsigned TLM_CYCLE_MS = 2630;
  localparam int unsigned TLM_ALARM_CYCLES = 2;
  localparam longint unsigned TLM_CYCLE_CLKS = (longint'(TLM_CYCLE_MS) * TLM_CLK_HZ) / 1000;
  localparam longint unsigned TLM_ALARM_CLKS = TLM_CYCLE_CLKS * TLM_ALARM_CYCLES;
  // Face interval above which a revolution counts as low, in milliseconds
  localparam int unsigned TLM_LOW_MS = 500;
  localparam longint unsigned TLM_LOW_CLKS = (longint'(TLM_LOW_MS) * TLM_CLK_HZ) / 1000;
  localparam int unsigned TLM_CNT_W = 28;
  localparam logic [1:0] TLM_SYNC_RST = 2'h0;
  typedef enum logic [1:0] {
    TLM_ST_AWAY = 2'h0,
    TLM_ST_FACE = 2'h1
  } tlm_state_e;
endpackage

//--- logic/tlm_monitor.sv
// Toner level monitor: times magnet facing per revolution, debounces low/full, raises a stuck-sensor alarm.
// Assumes sensor_i and motor_run_i are asynchronous pins; single clock, synchronous reset.
//
// Behaviour
// - Long facing interval is low, short is full
// - Set toner low after two low revolutions
// - Clear toner low after two full revolutions
// - Alarm after two sensor cycles without change
// - Freeze all evaluation while drum motor stopped
`timescale 1ns/100ps
module tlm_monitor
  import tlm_pkg::*;
#(
  parameter logic [TLM_CNT_W-1:0] LOW_CLKS = TLM_CNT_W'(TLM_LOW_CLKS),
  parameter logic [TLM_CNT_W-1:0] ALARM_CLKS = TLM_CNT_W'(TLM_ALARM_CLKS)
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sensor_i,
  input wire logic motor_run_i,
  output logic toner_low_o,
  output logic sensor_alarm_o,
  output logic rev_done_o,
  output logic rev_low_o
);
  // Pin order inside the synchroniser vector
  localparam int unsigned PIN_N = 2;
  localparam int unsigned PIN_SENS = 0;
  localparam int unsigned PIN_RUN = 1;

  // Pins and their synchronised copies
  logic [PIN_N-1:0] pin_async;
  logic [PIN_N-1:0] pin_sync;
  logic sens;
  logic run;

  // Edge detection
  logic sens_prev_reg, sens_prev_next;
  logic edge_seen;

  // Stuck-sensor alarm
  logic [TLM_CNT_W-1:0] idle_cnt_reg, idle_cnt_next;
  logic alarm_reg, alarm_next;
  logic idle_limit;

  // Facing interval per revolution
  tlm_state_e state_reg, state_next;
  logic [TLM_CNT_W-1:0] face_cnt_reg, face_cnt_next;
  logic done_reg, done_next;
  logic rlow_reg, rlow_next;
  logic rev_end;
  logic rev_low;

  // Two-in-a-row status filter
  logic last_low_reg, last_low_next;
  logic have_last_reg, have_last_next;
  logic low_reg, low_next;
  logic two_low;
  logic two_full;

  // Bit PIN_SENS is the sensor, bit PIN_RUN the motor
  assign pin_async = {motor_run_i, sensor_i};

  // Two flops per pin; the first stage is read only by the second
  // Costs two cycles of latency on every sensor and motor change
  for (genvar g = 0; g < PIN_N; g++) begin : g_sync
    logic [1:0] sync_reg;
    logic [1:0] sync_next;

    always_comb begin
      sync_next = {sync_reg[0], pin_async[g]};
    end

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        sync_reg <= TLM_SYNC_RST;
      end else begin
        sync_reg <= sync_next;
      end
    end

    assign pin_sync[g] = sync_reg[1];
  end

  assign sens = pin_sync[PIN_SENS];
  assign run = pin_sync[PIN_RUN];

  // Previous level follows even while stopped, so edges during a stop are dropped
  always_comb begin
    sens_prev_next = sens;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sens_prev_reg <= 1'b0;
    end else begin
      sens_prev_reg <= sens_prev_next;
    end
  end

  assign edge_seen = sens ^ sens_prev_reg;

  // Alarm shows ALARM_CLKS + 1 cycles after the last synced change
  assign idle_limit = idle_cnt_reg >= ALARM_CLKS - 1'b1;

  always_comb begin
    idle_cnt_next = idle_cnt_reg;
    alarm_next = alarm_reg;
    if (run) begin
      // Any change restarts the timing and drops the alarm
      if (edge_seen) begin
        idle_cnt_next = '0;
        alarm_next = 1'b0;
      end else if (idle_limit) begin
        // Counter parks at the limit instead of wrapping
        alarm_next = 1'b1;
      end else begin
        idle_cnt_next = idle_cnt_reg + 1'b1;
      end
    end
  end

  // Counters are frozen, not cleared, while the motor is stopped
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      idle_cnt_reg <= '0;
      alarm_reg <= 1'b0;
    end else begin
      idle_cnt_reg <= idle_cnt_next;
      alarm_reg <= alarm_next;
    end
  end

  // Strictly greater: an interval equal to the threshold reads full
  assign rev_low = face_cnt_reg > LOW_CLKS;
  // Revolution ends on the synced falling level while facing
  assign rev_end = run && (state_reg == TLM_ST_FACE) && !sens;

  always_comb begin
    state_next = state_reg;
    face_cnt_next = face_cnt_reg;
    done_next = 1'b0;
    rlow_next = rlow_reg;
    if (run) begin
      case (state_reg)
        TLM_ST_AWAY: begin
          if (sens) begin
            state_next = TLM_ST_FACE;
            face_cnt_next = '0;
          end
        end
        TLM_ST_FACE: begin
          if (!sens) begin
            state_next = TLM_ST_AWAY;
            done_next = 1'b1;
            rlow_next = rev_low;
          end else if (face_cnt_reg != '1) begin
            // Saturate so a stuck magnet still reads long
            face_cnt_next = face_cnt_reg + 1'b1;
          end
        end
        default: begin
          state_next = TLM_ST_AWAY;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= TLM_ST_AWAY;
      face_cnt_reg <= '0;
      done_reg <= 1'b0;
      rlow_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      face_cnt_reg <= face_cnt_next;
      done_reg <= done_next;
      rlow_reg <= rlow_next;
    end
  end

  assign two_low = have_last_reg && last_low_reg && rev_low;
  assign two_full = have_last_reg && !last_low_reg && !rev_low;

  always_comb begin
    last_low_next = last_low_reg;
    have_last_next = have_last_reg;
    low_next = low_reg;
    if (rev_end) begin
      last_low_next = rev_low;
      have_last_next = 1'b1;
      // First revolution after reset only seeds the history
      if (two_low) begin
        low_next = 1'b1;
      end else if (two_full) begin
        low_next = 1'b0;
      end
    end
  end

  // History survives a stop so a pair may span it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      last_low_reg <= 1'b0;
      have_last_reg <= 1'b0;
      low_reg <= 1'b0;
    end else begin
      last_low_reg <= last_low_next;
      have_last_reg <= have_last_next;
      low_reg <= low_next;
    end
  end

  // All outputs straight from flops
  assign toner_low_o = low_reg;
  assign sensor_alarm_o = alarm_reg;
  assign rev_done_o = done_reg;
  assign rev_low_o = rlow_reg;

endmodule

//--- sim/tlm_chk_monitor.sv
// Checker on the monitor ports: pulse shape, status changes, alarm and stop behaviour.
// Assumes one clock and a synchronous active-high reset; sees only the monitor's ports.
`timescale 1ns/100ps
module tlm_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sensor_i,
  input wire logic motor_run_i,
  input wire logic toner_low_o,
  input wire logic sensor_alarm_o,
  input wire logic rev_done_o,
  input wire logic rev_low_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  pulse_one_a: assert property (rev_done_o |=> !rev_done_o) else $error("long pulse");
  set_low_a: assert property ($rose(toner_low_o) |-> rev_done_o && rev_low_o) else $error("bad set");
  clr_low_a: assert property ($fell(toner_low_o) |-> rev_done_o && !rev_low_o) else $error("bad clear");
  hold_low_a: assert property (!rev_done_o |-> $stable(toner_low_o)) else $error("low moved");
  alarm_clr_a: assert property (sensor_alarm_o && motor_run_i && $changed(sensor_i)
    |-> ##[1:4] !sensor_alarm_o) else $error("alarm stuck");
  stop_hold_a: assert property (!motor_run_i [*6] |-> !rev_done_o && $stable(sensor_alarm_o))
    else $error("ran stopped");
endmodule
bind tlm_monitor tlm_chk u_tlm_chk (.*);

//--- sim/tlm_sensor_model.sv
// Sensor model: faces the plate for len_i clocks after a load; low between.
// Assumes the bench loads len_i for one cycle only, on the monitor's clock.
`timescale 1ns/100ps
module tlm_sensor_model (input wire logic clk_i, input wire logic [7:0] len_i, output logic sensor_o);
  logic [7:0] cnt_reg = 8'h00;
  always_ff @(posedge clk_i) cnt_reg <= (len_i != 8'h00) ? len_i : cnt_reg - 8'(sensor_o);
  assign sensor_o = cnt_reg != 8'h00;
endmodule

//--- sim/toner_level_monitor_tb_top.sv
// Bench: monitor with sensor model; short counts keep the run brief.
// Assumes the bound checker and a 50 ns clock; inputs move 5 ns after each edge.
`timescale 1ns/100ps
module toner_level_monitor_tb_top;
  logic clk_i = 1'b0, reset_i = 1'b1, motor_run_i = 1'b1, sensor_i, toner_low_o, sensor_alarm_o, rev_done_o, rev_low_o;
  logic [7:0] len = 8'h00;
  int mismatches = 0, check_count = 0, cycles = 0;
  always #25 clk_i = ~clk_i;
  tlm_monitor #(.LOW_CLKS(28'h14), .ALARM_CLKS(28'h64)) u_tlm_monitor (.clk_i(clk_i), .reset_i(reset_i),
    .sensor_i(sensor_i), .motor_run_i(motor_run_i), .toner_low_o(toner_low_o),
    .sensor_alarm_o(sensor_alarm_o), .rev_done_o(rev_done_o), .rev_low_o(rev_low_o));
  tlm_sensor_model u_tlm_sensor_model (.clk_i, .len_i(len), .sensor_o(sensor_i));
  task automatic chk(string s, logic e, logic g);
    check_count++;
    mismatches += int'(g !== e);
    if (g !== e) $display("mismatch %s expected %b seen %b", s, e, g);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  task automatic rev(logic [7:0] n, logic d, logic l);
    len = n;
    tick(1);
    len = 8'h00;
    for (int k = 0; k < 99 && rev_done_o !== 1'b1; k++)
      tick(1);
    chk("done", d, rev_done_o);
    chk("class", l, rev_low_o);
  endtask
  task automatic t_lvl;
    rev(8'h28, 1, 1);
    rev(8'h28, 1, 1);
    chk("low", 1, toner_low_o);
    rev(8'h05, 1, 0);
    rev(8'h05, 1, 0);
    chk("low", 0, toner_low_o);
    $display("lvl done");
  endtask
  task automatic t_flt;
    tick(105);
    chk("alarm", 1, sensor_alarm_o);
    rev(8'h05, 1, 0);
    chk("alarm", 0, sensor_alarm_o);
    motor_run_i = 1'b0;
    tick(4);
    rev(8'h28, 0, 0);
    chk("alarm", 0, sensor_alarm_o);
    $display("flt done");
  endtask
  task automatic tally_and_finish;
    mismatches += int'(cycles >= 2000);
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i)
    if (++cycles == 2000) tally_and_finish;
  initial begin
    tick(4);
    reset_i = 1'b0;
    t_lvl;
    t_flt;
    tally_and_finish;
  end
endmodule
